// ### prs_defines.vh
// Purpose: Shared constants for the phase resync timer and serial load path.
// Assumes: Control words use the low three bits as the latch address.
// Notes:   Bus offsets are byte addresses of 32-bit words.
`ifndef PRS_DEFINES_VH
`define PRS_DEFINES_VH

`define PRS_WORD_W        32
`define PRS_ADDR_LSB      0
`define PRS_ADDR_MSB      2
`define PRS_LATCH_CTRL1   3'h1
`define PRS_LATCH_CTRL3   3'h3
`define PRS_FIELD_LSB     3
`define PRS_FIELD_MSB     14
`define PRS_MODE_LSB      15
`define PRS_MODE_MSB      16
`define PRS_MODE_RESYNC   2'h2
`define PRS_PHASE_LSB     15
`define PRS_PHASE_MSB     26
`define PRS_CTRL1_RST     32'h00000001
`define PRS_CTRL3_RST     32'h00000003
`define PRS_OFS_CTRL1     4'h0
`define PRS_OFS_CTRL3     4'h4
`define PRS_OFS_STATUS    4'h8
`define PRS_SYNC_TARGET   2'h2

`endif

// ### prs_phase_resync.v
// Purpose: Three-wire serial load path and phase resync timer.
// Assumes: Serial pins and the reference clock are asynchronous to i_sys_clk.
// Notes:   Reference and serial clocks must be well below a quarter of i_sys_clk.
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "prs_defines.vh"

// Summary of operation
// - Mode field bits 16:15 of control 3 equal to 1,0 selects resync.
// - In resync mode a pulse issues every divider times modulus reference periods.
// - Divider value sits in control 3 bits 14:3, range 1 to 4095.
// - Modulus for the interval comes from control 1 bits 14:3.
// - Second sync pulse after a load strobe rise realigns output phase.
// - Phase word in control 1 sets offset, modulus steps per full turn.
// - Shift a bit each serial clock rise; load strobe rise latches word.
module prs_phase_resync #(
  parameter FIELD_W = 12
) (
  // Clock and reset
  input  wire                     i_sys_clk,
  input  wire                     i_reset_n,
  // Serial link pins
  input  wire                     i_serial_clk,
  input  wire                     i_serial_data,
  input  wire                     i_load_strobe,
  // PFD reference
  input  wire                     i_pfd_ref,
  // Register port
  input  wire [3:0]               i_reg_addr,
  input  wire [31:0]              i_reg_wdata,
  input  wire                     i_reg_wr,
  input  wire                     i_reg_rd,
  output reg  [31:0]              o_reg_rdata,
  // Resync outputs
  output reg                      o_resync_mode,
  output reg                      o_sync_pulse,
  output reg                      o_realign,
  output reg  [FIELD_W-1:0]       o_phase_word
);

  // Bit positions of the four pins inside the synchroniser bank.
  localparam PIN_SCLK  = 0;
  localparam PIN_SDATA = 1;
  localparam PIN_LOAD  = 2;
  localparam PIN_REF   = 3;
  // The load strobe rests high, so its chain resets high and no false edge follows reset.
  localparam [3:0]         PIN_IDLE  = 4'h4;
  // A one at field width keeps the counter sums from widening.
  localparam [FIELD_W-1:0] FIELD_ONE = {{(FIELD_W-1){1'b0}}, 1'b1};

  wire [3:0]          pin_raw;
  wire [3:0]          pin_s1;
  wire [3:0]          pin_s2;
  reg  [31:0]         shift_ff;
  reg  [31:0]         ctrl1_ff;
  reg  [31:0]         ctrl3_ff;
  reg  [FIELD_W-1:0]  inner_ff;
  reg  [FIELD_W-1:0]  outer_ff;
  reg  [1:0]          sync_cnt_ff;
  reg  [FIELD_W-1:0]  nxt_inner;
  reg  [FIELD_W-1:0]  nxt_outer;
  reg                 nxt_pulse;
  reg  [1:0]          nxt_sync_cnt;
  reg                 nxt_realign;
  reg  [FIELD_W-1:0]  nxt_phase;
  wire                ser_rise;
  wire                le_rise;
  wire                ref_rise;
  wire                mode_on;
  wire [FIELD_W-1:0]  modulus;
  wire [FIELD_W-1:0]  divider;
  wire [FIELD_W-1:0]  phase_raw;
  wire [2:0]          latch_addr;
  wire [FIELD_W-1:0]  phase_wrap;
  wire [31:0]         status_word;

  // Stage 0 of each chain feeds only stage 1; edges use stages 1 and 2.
  assign ser_rise   = pin_s1[PIN_SCLK] & ~pin_s2[PIN_SCLK];
  assign le_rise    = pin_s1[PIN_LOAD] & ~pin_s2[PIN_LOAD];
  assign ref_rise   = pin_s1[PIN_REF] & ~pin_s2[PIN_REF];
  assign mode_on    = (ctrl3_ff[`PRS_MODE_MSB:`PRS_MODE_LSB] == `PRS_MODE_RESYNC);
  assign modulus    = ctrl1_ff[`PRS_FIELD_MSB:`PRS_FIELD_LSB];
  assign divider    = ctrl3_ff[`PRS_FIELD_MSB:`PRS_FIELD_LSB];
  assign phase_raw  = ctrl1_ff[`PRS_PHASE_MSB:`PRS_PHASE_LSB];
  assign latch_addr = shift_ff[`PRS_ADDR_MSB:`PRS_ADDR_LSB];
  // Words at or past a nonzero modulus wrap once; words of twice the modulus or more stay past one turn.
  assign phase_wrap = (phase_raw >= modulus && modulus != {FIELD_W{1'b0}}) ?
                      phase_raw - modulus : phase_raw;
  assign status_word = {28'h0000000, sync_cnt_ff, o_realign, mode_on};

  assign pin_raw = {i_pfd_ref, i_load_strobe, i_serial_data, i_serial_clk};

  // Stage 0 may go metastable, so nothing but stage 1 reads it.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pin_sync
      reg [2:0] chain_ff;
      always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          chain_ff <= {3{PIN_IDLE[g]}};
        end else begin
          chain_ff <= {chain_ff[1:0], pin_raw[g]};
        end
      end
      assign pin_s1[g] = chain_ff[1];
      assign pin_s2[g] = chain_ff[2];
    end
  endgenerate

  // Data is taken from stage 2 so it lines up with the detected clock edge.
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shift_ff <= 32'h00000000;
    end else if (ser_rise) begin
      shift_ff <= {shift_ff[30:0], pin_s2[PIN_SDATA]};
    end
  end

  // A serial load wins over a bus write in the same cycle.
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl1_ff <= `PRS_CTRL1_RST;
      ctrl3_ff <= `PRS_CTRL3_RST;
    end else begin
      if (le_rise && latch_addr == `PRS_LATCH_CTRL1) begin
        ctrl1_ff <= shift_ff;
      end else if (i_reg_wr && i_reg_addr == `PRS_OFS_CTRL1) begin
        ctrl1_ff <= i_reg_wdata;
      end
      if (le_rise && latch_addr == `PRS_LATCH_CTRL3) begin
        ctrl3_ff <= shift_ff;
      end else if (i_reg_wr && i_reg_addr == `PRS_OFS_CTRL3) begin
        ctrl3_ff <= i_reg_wdata;
      end
    end
  end

  // Interval counter: inner counts reference edges per modulus, outer counts moduli.
  // A zero divider or modulus is treated as one so the timer never stalls.
  always @* begin
    nxt_inner = inner_ff;
    nxt_outer = outer_ff;
    nxt_pulse = 1'b0;
    if (!mode_on) begin
      nxt_inner = {FIELD_W{1'b0}};
      nxt_outer = {FIELD_W{1'b0}};
    end else if (ref_rise) begin
      if (inner_ff + FIELD_ONE >= modulus) begin
        nxt_inner = {FIELD_W{1'b0}};
        if (outer_ff + FIELD_ONE >= divider) begin
          nxt_outer = {FIELD_W{1'b0}};
          nxt_pulse = 1'b1;
        end else begin
          nxt_outer = outer_ff + FIELD_ONE;
        end
      end else begin
        nxt_inner = inner_ff + FIELD_ONE;
      end
    end
  end

  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      inner_ff      <= {FIELD_W{1'b0}};
      outer_ff      <= {FIELD_W{1'b0}};
      o_sync_pulse  <= 1'b0;
      o_resync_mode <= 1'b0;
    end else begin
      inner_ff      <= nxt_inner;
      outer_ff      <= nxt_outer;
      o_sync_pulse  <= nxt_pulse;
      o_resync_mode <= mode_on;
    end
  end

  // The count saturates at the target, so only one realign follows each load.
  // Bus writes leave the count alone; only a serial load starts a new frequency.
  always @* begin
    nxt_sync_cnt = sync_cnt_ff;
    nxt_realign  = 1'b0;
    nxt_phase    = o_phase_word;
    // A load edge restarts the count even if a pulse lands in the same cycle.
    if (le_rise) begin
      nxt_sync_cnt = 2'h0;
    end else if (nxt_pulse && sync_cnt_ff != `PRS_SYNC_TARGET) begin
      nxt_sync_cnt = sync_cnt_ff + 2'h1;
      if (sync_cnt_ff == `PRS_SYNC_TARGET - 2'h1) begin
        nxt_realign = 1'b1;
        nxt_phase   = phase_wrap;
      end
    end
  end

  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync_cnt_ff  <= 2'h0;
      o_realign    <= 1'b0;
      o_phase_word <= {FIELD_W{1'b0}};
    end else begin
      sync_cnt_ff  <= nxt_sync_cnt;
      o_realign    <= nxt_realign;
      o_phase_word <= nxt_phase;
    end
  end

  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 32'h00000000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `PRS_OFS_CTRL1:  o_reg_rdata <= ctrl1_ff;
        `PRS_OFS_CTRL3:  o_reg_rdata <= ctrl3_ff;
        `PRS_OFS_STATUS: o_reg_rdata <= status_word;
        default:         o_reg_rdata <= 32'h00000000;
      endcase
    end else begin
      o_reg_rdata <= 32'h00000000;
    end
  end

endmodule

// ### prs_properties.sv
// Purpose: Port checker for prs_phase_resync.
// Assumes: Reference pin levels last at least three clocks.
// Notes: Serial load latency is left to the bench.
`timescale 1ns/1ps
module prs_props (
  input wire        i_sys_clk,
  input wire        i_reset_n,
  input wire [3:0]  i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire        i_reg_wr,
  input wire        i_reg_rd,
  input wire [31:0] o_reg_rdata,
  input wire        o_resync_mode,
  input wire        o_sync_pulse,
  input wire        o_realign,
  input wire [11:0] o_phase_word
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  wire w3 = i_reg_wr && i_reg_addr == 4'h4;
  a_mode_on: assert property (w3 && i_reg_wdata[16:15] == 2'h2 |-> ##[1:2] o_resync_mode) else $error("mode on");
  a_mode_off: assert property (w3 && i_reg_wdata[16:15] != 2'h2 |-> ##[1:2] !o_resync_mode) else $error("mode off");
  a_sync_gap: assert property (o_sync_pulse |=> !o_sync_pulse [*5]) else $error("sync gap");
  a_sync_mode: assert property (o_sync_pulse |-> o_resync_mode) else $error("sync mode");
  a_realign_sync: assert property (o_realign |-> o_sync_pulse) else $error("realign");
  a_phase_hold: assert property ($changed(o_phase_word) |-> o_realign || $past(o_realign)) else $error("phase");
  a_rdata_idle: assert property (!i_reg_rd |=> o_reg_rdata == 32'h0) else $error("rdata idle");
  a_unmapped_rd: assert property (i_reg_rd && i_reg_addr > 4'h8 |=> o_reg_rdata == 32'h0) else $error("unmapped");
  cover property (o_realign);
  cover property (o_sync_pulse && !o_realign);
  cover property (i_reg_rd ##1 o_reg_rdata != 32'h0);
endmodule
bind prs_phase_resync prs_props prs_props_i (.i_sys_clk, .i_reset_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
  .i_reg_rd, .o_reg_rdata, .o_resync_mode, .o_sync_pulse, .o_realign, .o_phase_word);

// ### prs_host_model.sv
// Purpose: Serial master for the three-wire load path.
// Assumes: One word at a time.
// Notes: Clock rests low and data inverts outside frames.
`timescale 1ns/1ps
module prs_host_model (
  output reg o_sclk,
  output reg o_sdata,
  output reg o_strobe
);
  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_strobe = 1'b1;
  end
  // The 1 ns offset adds up per word: after a bus cycle pin edges land on falling edges, the next word 1 ns later, a third on rising edges.
  task send_word(input [31:0] w);
    integer k;
    #1 o_strobe = 1'b0;
    for (k = 31; k >= 0; k = k - 1) begin
      o_sdata = w[k];
      #16 o_sclk = 1'b1;
      #16 o_sclk = 1'b0;
    end
    #16 o_strobe = 1'b1;
    o_sdata = ~o_sdata;
    // Strobe stays high for several system clocks so the next frame cannot hide its rise.
    #32;
  endtask
endmodule

// ### tb_prs_phase_resync.sv
// Purpose: Self-checking bench for prs_phase_resync.
// Assumes: Reference period of 16 clocks, serial clock 32 ns.
// Notes: Interval figures rely on the reference staying clock aligned.
`timescale 1ns/1ps
module tb_prs_phase_resync;
  reg clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  reg [3:0] rc = 4'h0, addr = 4'h0;
  reg [31:0] wd = 32'h0;
  wire [31:0] rdata;
  wire [11:0] phase;
  wire mode, sync, realign, sclk, sdata, strobe;
  integer err_total = 0, checked = 0, n, m;
  prs_host_model prs_host_model_i (.o_sclk(sclk), .o_sdata(sdata), .o_strobe(strobe));
  prs_phase_resync prs_phase_resync_i (.i_sys_clk(clk), .i_reset_n(rst_n), .i_serial_clk(sclk),
    .i_serial_data(sdata), .i_load_strobe(strobe), .i_pfd_ref(rc[3]), .i_reg_addr(addr), .i_reg_wdata(wd),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_resync_mode(mode), .o_sync_pulse(sync),
    .o_realign(realign), .o_phase_word(phase));
  initial forever #2 clk = ~clk;
  always @(posedge clk) rc <= rc + 4'h1;
  task chk(input [31:0] s, input [31:0] e);
    checked = checked + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task print_verdict;
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task wait_sync;
    @(posedge clk);
    #1;
    for (n = 1; n < 2000 && sync !== 1'b1; n = n + 1) begin
      @(posedge clk);
      #1;
    end
    if (sync !== 1'b1) begin
      err_total = err_total + 1;
      print_verdict;
    end
  endtask
  task t_regs;
    bus(1'b0, 4'h0, 32'h0);
    chk(rdata, 32'h1);
    bus(1'b0, 4'h4, 32'h0);
    chk(rdata, 32'h3);
    bus(1'b1, 4'hc, 32'hffffffff);
    bus(1'b0, 4'hc, 32'h0);
    chk(rdata, 32'h0);
  endtask
  task t_mode;
    for (m = 0; m < 4; m = m + 1) begin
      bus(1'b1, 4'h4, {15'h0, m[1:0], 12'h001, 3'h3});
      @(posedge clk);
      #1 chk(mode, m == 2);
    end
    bus(1'b0, 4'h4, 32'h0);
    chk(rdata, 32'h0001800b);
  endtask
  task t_load;
    prs_host_model_i.send_word(32'h00038029);
    prs_host_model_i.send_word(32'hfffffffa);
    prs_host_model_i.send_word(32'h00010023);
    repeat (8) @(posedge clk);
    bus(1'b0, 4'h0, 32'h0);
    chk(rdata, 32'h00038029);
    bus(1'b0, 4'h4, 32'h0);
    chk(rdata, 32'h00010023);
    chk(mode, 1'b1);
  endtask
  // Reloading right after a pulse lands the strobe well inside the next interval.
  task t_resync;
    wait_sync;
    chk(realign, 1'b0);
    wait_sync;
    chk(n, 320);
    chk(realign, 1'b1);
    wait_sync;
    chk(realign, 1'b0);
    chk(phase, 12'h2);
    bus(1'b0, 4'h8, 32'h0);
    chk(rdata, 32'h9);
    prs_host_model_i.send_word(32'h00010023);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_mode;
    t_load;
    t_resync;
    t_resync;
    print_verdict;
  end
endmodule
